// [bench/periph_model.sv]
// peripheral model that drives the event and status inputs of the block
`timescale 1ns/1ps

module periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // event requests and configuration from the bench
  input wire logic [9:0] evtReq,
  input wire logic [4:0] pinCfg,
  input wire logic capCfg,
  // event and status outputs
  output irq_flags_pkg::periph_evt_t periph
);
  // ========================================
  // each request bit becomes one registered event cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      periph.intervalCount <= 8'h10;
    end else if (evtReq[0]) begin
      periph.intervalCount <= 8'hFF;
    end else if (periph.intervalCount == 8'hFF) begin
      periph.intervalCount <= 8'h00;
    end
    periph.serialDone <= evtReq[1];
    // bit 8 transfers without the enable, so no flag may follow
    periph.directXfer <= evtReq[2] | evtReq[8];
    periph.directTransferEnable <= evtReq[2];
    // busy normally high; one low cycle ends a conversion
    periph.converterStartBusy <= ~evtReq[3];
    periph.captureMode <= capCfg;
    periph.captureOverflow <= evtReq[4] | evtReq[9];
    periph.overflowIrqEnable <= evtReq[4];
    // bit 7 gives a high-byte match in 16-bit mode: no flag
    periph.compareMode16 <= evtReq[6] | evtReq[7];
    periph.compareCounterFull <= evtReq[6] ? 16'h5678 :
      (evtReq[5] | evtReq[7]) ? 16'h5600 : 16'h1234;
    periph.compareValueFull <= 16'h5678;
    periph.pinIsIrq <= pinCfg;
  end
endmodule

// [bench/tb_interrupt_request_flags.sv]
// self-checking bench for the interrupt request flag block
`timescale 1ns/1ps

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  failCount++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end

module tb_interrupt_request_flags;
  // ========================================
  // signals
  logic clk, reset, read, write, waitrequest, irq, captureInputPin, capCfg;
  logic [4:0] address, extRequestPin, pinCfg;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable;
  logic [7:0] flagsOne, flagsTwo;
  logic [9:0] evtReq;
  irq_flags_pkg::periph_evt_t periph;
  int failCount, comparisons;
  // value read back after each event request, in request order
  logic [7:0] expBit [10] = '{8'hA0, 8'h60, 8'h80, 8'h40, 8'h10, 8'h08,
    8'h08, 8'h00, 8'h00, 8'h00};

  interrupt_request_flags interrupt_request_flags_inst (.clk(clk),
    .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .periph(periph),
    .extRequestPin(extRequestPin), .captureInputPin(captureInputPin),
    .flagsOne(flagsOne), .flagsTwo(flagsTwo), .irq(irq));
  periph_model periph_model_inst (.clk(clk), .reset(reset),
    .evtReq(evtReq), .pinCfg(pinCfg), .capCfg(capCfg), .periph(periph));

  // ========================================
  // clock, watchdog, closing
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    failCount++;
    tallyAndFinish();
  end
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ========================================
  // avalon transfers: hold until waitrequest is sampled low
  task automatic busXfer(input logic wr, input logic [4:0] a,
    input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    // only the watchdog ends a wait whose answer never comes
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // let one edge pass so the next request is a fresh assignment
    @(posedge clk);
  endtask
  task automatic pulse(input logic [9:0] m);
    evtReq <= m;
    @(posedge clk);
    evtReq <= 10'h000;
  endtask
  task automatic waitCycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ========================================
  // test sequence
  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = 5'h00;
    writedata = 32'h0000_0000; byteenable = 4'h0; evtReq = 10'h000;
    extRequestPin = 5'h1F; captureInputPin = 1'b1;
    pinCfg = 5'h0F; capCfg = 1'b1;
    failCount = 0; comparisons = 0;
    waitCycles(6);
    reset <= 1'b0;
    @(posedge clk);
    // reset values and fixed bits
    busXfer(1'b0, 5'h00, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0020)
    busXfer(1'b0, 5'h04, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0000)
    busXfer(1'b0, 5'h08, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0000)
    busXfer(1'b1, 5'h00, 32'h0000_00FF, 4'h1);
    `CHECK(flagsOne, 8'h20)
    busXfer(1'b1, 5'h04, 32'h0000_00FF, 4'h1);
    `CHECK(flagsTwo, 8'h20)
    busXfer(1'b1, 5'h04, 32'h0, 4'h1);
    `CHECK(flagsTwo, 8'h00)
    $display("test reset and write-one done");
    // each of the ten event requests, pulsed for one cycle, read 20 cycles later, then cleared by a zero
    for (int i = 0; i < 10; i++) begin
      pulse(10'h001 << i);
      waitCycles(20);
      address <= (i < 2) ? 5'h00 : 5'h04;
      @(posedge clk);
      busXfer(1'b0, address, 32'h0, 4'hF);
      `CHECK(rd[7:0], expBit[i])
      busXfer(1'b1, address, 32'h0, 4'h1);
      `CHECK(flagsOne | flagsTwo, 8'h20)
    end
    $display("test event sources done");
    // pin edges: default falling, pin 4 not configured
    extRequestPin <= 5'h0E;
    waitCycles(8);
    `CHECK(flagsOne, 8'h21)
    busXfer(1'b1, 5'h08, 32'h0000_0022, 4'h1);
    extRequestPin <= 5'h0C;
    captureInputPin <= 1'b0;
    waitCycles(8);
    `CHECK({flagsOne, flagsTwo}, 16'h2100)
    extRequestPin <= 5'h0E;
    captureInputPin <= 1'b1;
    waitCycles(8);
    `CHECK({flagsOne, flagsTwo}, 16'h2310)
    busXfer(1'b0, 5'h08, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0022)
    $display("test pin edges done");
    // interrupt output: enable, clear register, mask
    busXfer(1'b1, 5'h0C, 32'h0000_1002, 4'h3);
    `CHECK(irq, 1'b1)
    busXfer(1'b1, 5'h10, 32'h0000_0002, 4'h1);
    `CHECK({flagsOne, irq}, 9'h043)
    busXfer(1'b1, 5'h04, 32'h0, 4'h1);
    `CHECK(irq, 1'b0)
    // clear register upper lane: refused without its byte enable
    pulse(10'h010);
    waitCycles(4);
    busXfer(1'b1, 5'h10, 32'h0000_1000, 4'h1);
    `CHECK({flagsTwo, irq}, 9'h021)
    busXfer(1'b1, 5'h10, 32'h0000_1000, 4'h2);
    `CHECK({flagsTwo, irq}, 9'h000)
    busXfer(1'b0, 5'h10, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0000)
    busXfer(1'b0, 5'h14, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0000)
    $display("test interrupt output done");
    // set and clear of the serial flag in the same cycle
    fork
      busXfer(1'b1, 5'h00, 32'h0000_00BF, 4'h1);
      pulse(10'h002);
    join
    `CHECK(flagsOne, 8'h61)
    $display("test set over clear done");
    // second reset in mid-run
    reset <= 1'b1;
    waitCycles(3);
    reset <= 1'b0;
    @(posedge clk);
    `CHECK({flagsOne, flagsTwo, irq}, 17'h0_4000)
    busXfer(1'b0, 5'h0C, 32'h0, 4'hF);
    `CHECK(rd, 32'h0000_0000)
    $display("test second reset done");
    tallyAndFinish();
  end
endmodule

// [hw/interrupt_request_flags.sv]
// interrupt request flag registers with an avalon-mm register slave
//
// Functional notes
// - flags stay set until software clears them
// - write 0 clears flag, write 1 ignored
// - first register: timer 7, serial 6, pins 4..0
// - interval counter wrap FF to 00 sets flag
// - serial transfer complete sets serial flag
// - first register bit 5 reads one, fixed
// - configured pin with selected edge sets flag
// - sleep direct transfer with enable sets flag
// - converter busy falling sets converter flag
// - second register bit 5 is plain storage
// - configured capture pin edge sets capture flag
// - capture overflow with enable sets capture flag
// - compare match per 8/16-bit mode sets flag
// - both registers 8 bits, first resets to 20h (bit 5 set), second to zero
// - edge select 0 falling, 1 rising, reset 0
// - request forwarded only while enable is one
`timescale 1ns/1ps
`include "irq_flags_defines.svh"

module interrupt_request_flags #(
  parameter int ADDR_WIDTH = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // peripheral events on the system clock
  input wire irq_flags_pkg::periph_evt_t periph,
  // asynchronous pins
  input wire logic [4:0] extRequestPin,
  input wire logic captureInputPin,
  // flag state and interrupt
  output logic [7:0] flagsOne,
  output logic [7:0] flagsTwo,
  output logic irq
);

  // ========================================
  // pin synchronisers and edge history
  logic [4:0] pinMeta_r;      // first stage, read only by second
  logic [4:0] pinSync_r;      // synchronised pin level
  logic [4:0] pinPrev_r;      // previous synchronised level
  logic capMeta_r;            // capture pin first stage
  logic capSync_r;            // capture pin synchronised
  logic capPrev_r;            // capture pin previous level

  // two flops then an edge history flop
  always_ff @(posedge clk) begin
    pinMeta_r <= extRequestPin;
    pinSync_r <= pinMeta_r;
    pinPrev_r <= pinSync_r;
    capMeta_r <= captureInputPin;
    capSync_r <= capMeta_r;
    capPrev_r <= capSync_r;
  end

  // ========================================
  // event history of peripheral inputs
  logic [7:0] intervalPrev_r;  // counter value one cycle ago
  logic busyPrev_r;            // converter busy one cycle ago
  logic matchPrev_r;           // compare match one cycle ago
  logic matchNow;              // compare match this cycle

  // match of high byte in 8-bit mode, whole word in 16-bit mode
  assign matchNow = periph.compareMode16 ?
    (periph.compareCounterFull == periph.compareValueFull) :
    (periph.compareCounterFull[15:8] ==
     periph.compareValueFull[15:8]);

  // history flops, reset so no false wrap or busy edge after reset; a match held through reset still sets the compare flag
  always_ff @(posedge clk) begin
    if (reset) begin
      intervalPrev_r <= 8'h00;
      busyPrev_r <= 1'b0;
      matchPrev_r <= 1'b0;
    end else begin
      intervalPrev_r <= periph.intervalCount;
      busyPrev_r <= periph.converterStartBusy;
      matchPrev_r <= matchNow;
    end
  end

  // ========================================
  // set events
  logic [5:0] edgeSel_r;       // edge select, 1 rising, 0 falling
  logic [4:0] pinEdge;         // selected edge seen on pin n
  logic capEdge;               // selected edge seen on capture pin
  logic intervalWrap;          // interval counter wrapped
  logic converterDone;         // conversion finished
  logic compareHit;            // new compare match
  logic captureSet;            // capture timer event
  logic directSet;             // direct transfer event
  logic [7:0] setOne;          // set vector for first register
  logic [7:0] setTwo;          // set vector for second register

  // per-pin edge choice
  assign pinEdge = (edgeSel_r[4:0] & pinSync_r & ~pinPrev_r) |
    (~edgeSel_r[4:0] & ~pinSync_r & pinPrev_r);
  assign capEdge = edgeSel_r[`BIT_EDGE_CAPTURE] ?
    (capSync_r & ~capPrev_r) : (~capSync_r & capPrev_r);
  assign intervalWrap = (intervalPrev_r == 8'hFF) &&
    (periph.intervalCount == 8'h00);
  assign converterDone = busyPrev_r & ~periph.converterStartBusy;
  assign compareHit = matchNow & ~matchPrev_r;
  assign captureSet = (capEdge & periph.captureMode) |
    (periph.captureOverflow & periph.overflowIrqEnable);
  assign directSet = periph.directXfer &
    periph.directTransferEnable;

  // placement of sources in the two registers
  assign setOne = {intervalWrap, periph.serialDone, 1'b0,
    pinEdge & periph.pinIsIrq};
  assign setTwo = {directSet, converterDone, 1'b0, captureSet,
    compareHit, 3'b000};

  // ========================================
  // bus decode
  logic waitReq_r;             // waitrequest flop
  logic waitReq_nxt;
  logic [31:0] readdata_r;     // read data flop
  logic wrTake;                // write accepted this edge
  logic hitOne;
  logic hitTwo;
  logic hitEdge;
  logic hitEnable;
  logic hitClear;
  logic [31:0] readSel;        // read mux output
  logic [15:0] enable_r;       // interrupt enable, same layout
  logic [7:0] flagsOne_r;
  logic [7:0] flagsTwo_r;

  assign hitOne = address == `OFF_FLAGS_ONE;
  assign hitTwo = address == `OFF_FLAGS_TWO;
  assign hitEdge = address == `OFF_EDGE_SEL;
  assign hitEnable = address == `OFF_IRQ_ENABLE;
  assign hitClear = address == `OFF_IRQ_CLEAR;
  assign wrTake = write & ~waitReq_r;

  // read mux, unmapped and write-only offsets read zero
  assign readSel = hitOne ? {24'h0000_00, flagsOne_r} :
    hitTwo ? {24'h0000_00, flagsTwo_r} :
    hitEdge ? {26'h000_0000, edgeSel_r} :
    hitEnable ? {16'h0000, enable_r} :
    32'h0000_0000;

  // one wait cycle per request, released the cycle after
  assign waitReq_nxt = (read | write) ? ~waitReq_r : 1'b1;

  // bus handshake flops
  always_ff @(posedge clk) begin
    if (reset) begin
      waitReq_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitReq_r <= waitReq_nxt;
      if (read && waitReq_r) begin
        readdata_r <= readSel;
      end
    end
  end

  // ========================================
  // flag and control registers
  logic [7:0] clrOne;          // bits cleared in first register
  logic [7:0] clrTwo;          // bits cleared in second register
  logic store_nxt;             // second register storage bit
  logic [7:0] flagsOne_nxt;
  logic [7:0] flagsTwo_nxt;
  logic [5:0] edgeSel_nxt;
  logic [15:0] enable_nxt;
  logic wrOneL0;
  logic wrTwoL0;
  logic wrClrL0;
  logic wrClrL1;
  logic irq_r;

  assign wrOneL0 = wrTake & hitOne & byteenable[0];
  assign wrTwoL0 = wrTake & hitTwo & byteenable[0];
  assign wrClrL0 = wrTake & hitClear & byteenable[0];
  assign wrClrL1 = wrTake & hitClear & byteenable[1];

  // zero written to a flag clears it, one is ignored
  assign clrOne = ((wrOneL0 ? ~writedata[7:0] : 8'h00) |
    (wrClrL0 ? writedata[7:0] : 8'h00)) & `FLAG_MASK_ONE;
  assign clrTwo = ((wrTwoL0 ? ~writedata[7:0] : 8'h00) |
    (wrClrL1 ? writedata[15:8] : 8'h00)) & `FLAG_MASK_TWO;
  assign store_nxt = wrTwoL0 ? writedata[`BIT_STORE_TWO] :
    flagsTwo_r[`BIT_STORE_TWO];

  // set applied after clear so a same-cycle event survives
  assign flagsOne_nxt = (((flagsOne_r & ~clrOne) | setOne) &
    `FLAG_MASK_ONE) | `RST_FLAGS_ONE;
  assign flagsTwo_nxt = (((flagsTwo_r & ~clrTwo) | setTwo) &
    `FLAG_MASK_TWO) |
    ({7'h00, store_nxt} << `BIT_STORE_TWO);
  assign edgeSel_nxt = (wrTake & hitEdge & byteenable[0]) ?
    writedata[5:0] : edgeSel_r;
  assign enable_nxt = {
    (wrTake & hitEnable & byteenable[1]) ? writedata[15:8] :
      enable_r[15:8],
    (wrTake & hitEnable & byteenable[0]) ? writedata[7:0] :
      enable_r[7:0]};

  // register file flops
  always_ff @(posedge clk) begin
    if (reset) begin
      flagsOne_r <= `RST_FLAGS_ONE;
      flagsTwo_r <= `RST_FLAGS_TWO;
      edgeSel_r <= `RST_EDGE_SEL;
      enable_r <= `RST_IRQ_ENABLE;
      irq_r <= 1'b0;
    end else begin
      flagsOne_r <= flagsOne_nxt;
      flagsTwo_r <= flagsTwo_nxt;
      edgeSel_r <= edgeSel_nxt;
      enable_r <= enable_nxt;
      irq_r <= |({flagsTwo_nxt, flagsOne_nxt} & enable_nxt &
        `IRQ_SRC_MASK);
    end
  end

  // ========================================
  // outputs, all from flops
  assign readdata = readdata_r;
  assign waitrequest = waitReq_r;
  assign flagsOne = flagsOne_r;
  assign flagsTwo = flagsTwo_r;
  assign irq = irq_r;

  // ========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // accepted write to the first flag register with byte lane 0 enabled
  sequence wrOneSeq;
    write && !waitrequest && address == `OFF_FLAGS_ONE &&
      byteenable[0];
  endsequence

  sequence pinFallSeq;
    $fell(pinSync_r[0]) && !edgeSel_r[0] && periph.pinIsIrq[0];
  endsequence

  sequence wrapSeq;
    !$past(reset) && $past(periph.intervalCount) == 8'hFF &&
      periph.intervalCount == 8'h00;
  endsequence

  sticky_flag_a: assert property (
    flagsOne[`BIT_INTERVAL] && !(write && address == `OFF_FLAGS_ONE)
    && !(write && address == `OFF_IRQ_CLEAR) |=>
    flagsOne[`BIT_INTERVAL])
    else $error("interval flag dropped without a clear");

  write_zero_a: assert property (
    wrOneSeq and !writedata[`BIT_SERIAL] && !periph.serialDone |=>
    !flagsOne[`BIT_SERIAL])
    else $error("write of zero did not clear serial flag");

  write_one_a: assert property (
    wrOneSeq and writedata[`BIT_SERIAL] && !flagsOne[`BIT_SERIAL]
    && !periph.serialDone |=> !flagsOne[`BIT_SERIAL])
    else $error("write of one set the serial flag");

  set_wins_a: assert property (
    wrOneSeq and !writedata[`BIT_SERIAL] && periph.serialDone |=>
    flagsOne[`BIT_SERIAL])
    else $error("serial event lost to a same-cycle clear");

  reserved_read_a: assert property (
    read && !waitrequest && address == `OFF_FLAGS_ONE |->
    readdata[`BIT_RSVD_ONE])
    else $error("reserved bit did not read as one");

  interval_wrap_a: assert property (
    wrapSeq |=> flagsOne[`BIT_INTERVAL])
    else $error("counter wrap did not set interval flag");

  pin_edge_a: assert property (
    pinFallSeq |=> flagsOne[0])
    else $error("falling edge on pin 0 did not set its flag");

  converter_done_a: assert property (
    $fell(periph.converterStartBusy) && !$past(reset) |=>
    flagsTwo[`BIT_CONVERTER])
    else $error("conversion end did not set converter flag");

  capture_ovf_a: assert property (
    periph.captureOverflow && periph.overflowIrqEnable |=>
    flagsTwo[`BIT_CAPTURE])
    else $error("enabled overflow did not set capture flag");

  compare_full_a: assert property (
    !matchPrev_r && periph.compareMode16 &&
    periph.compareCounterFull == periph.compareValueFull |=>
    flagsTwo[`BIT_COMPARE])
    else $error("16-bit match did not set compare flag");

  direct_xfer_a: assert property (
    periph.directXfer && periph.directTransferEnable |=>
    flagsTwo[`BIT_DIRECT])
    else $error("direct transfer did not set its flag");

  reset_value_a: assert property (
    $fell(reset) |-> flagsOne == `RST_FLAGS_ONE &&
    flagsTwo == `RST_FLAGS_TWO)
    else $error("flag registers wrong after reset");

  irq_gate_a: assert property (
    ##1 irq == |({flagsTwo, flagsOne} & enable_r & `IRQ_SRC_MASK))
    else $error("interrupt output not gated by enables");

  bus_answer_a: assert property (
    (read || write) && waitrequest ##1 (read || write) |->
    !waitrequest)
    else $error("slave took more than one wait cycle");

  // capture pin rising edge while rising is selected
  sequence capRiseSeq;
    $rose(capSync_r) && edgeSel_r[`BIT_EDGE_CAPTURE] &&
      periph.captureMode;
  endsequence

  capture_edge_a: assert property (
    capRiseSeq |=> flagsTwo[`BIT_CAPTURE])
    else $error("selected capture edge did not set capture flag");

  store_bit_a: assert property (
    write && !waitrequest && address == `OFF_FLAGS_TWO &&
    byteenable[0] |=>
    flagsTwo[`BIT_STORE_TWO] == $past(writedata[`BIT_STORE_TWO]))
    else $error("storage bit did not take the written value");

endmodule

// [hw/irq_flags_defines.svh]
// register offsets, bit positions and reset values of the flag block
`ifndef IRQ_FLAGS_DEFINES_SVH
`define IRQ_FLAGS_DEFINES_SVH

// ========================================
// register byte offsets
`define OFF_FLAGS_ONE 5'h00
`define OFF_FLAGS_TWO 5'h04
`define OFF_EDGE_SEL 5'h08
`define OFF_IRQ_ENABLE 5'h0C
`define OFF_IRQ_CLEAR 5'h10

// ========================================
// bit positions in the first request register
`define BIT_INTERVAL 7
`define BIT_SERIAL 6
`define BIT_RSVD_ONE 5

// ========================================
// bit positions in the second request register
`define BIT_DIRECT 7
`define BIT_CONVERTER 6
`define BIT_STORE_TWO 5
`define BIT_CAPTURE 4
`define BIT_COMPARE 3

// ========================================
// edge select: pins 4..0, capture pin at bit 5
`define BIT_EDGE_CAPTURE 5

// ========================================
// reset values and masks
`define RST_FLAGS_ONE 8'h20
`define RST_FLAGS_TWO 8'h00
`define RST_EDGE_SEL 6'h00
`define RST_IRQ_ENABLE 16'h0000
`define FLAG_MASK_ONE 8'hDF
`define FLAG_MASK_TWO 8'hD8
`define IRQ_SRC_MASK 16'hD8DF

`endif

// [hw/irq_flags_pkg.sv]
// types shared by the interrupt request flag block
package irq_flags_pkg;

  // ========================================
  // event and status inputs from peripherals on the system clock
  typedef struct packed {
    logic [7:0] intervalCount;         // interval timer 8-bit counter
    logic serialDone;                  // serial channel transfer complete
    logic directXfer;                  // sleep performed a direct transfer
    logic directTransferEnable;        // control bit in system_control_two
    logic converterStartBusy;          // converter start/busy bit
    logic captureMode;                 // capture pin set as capture input
    logic captureOverflow;             // capture timer counter overflow
    logic overflowIrqEnable;           // overflow interrupt enable bit
    logic compareMode16;               // compare timer in 16-bit mode
    logic [15:0] compareCounterFull;   // compare timer counter
    logic [15:0] compareValueFull;     // compare timer compare value
    logic [4:0] pinIsIrq;              // pin n configured as request input
  } periph_evt_t;

endpackage
